/* design/twc_defs.svh */
// Constants of the three-wire configuration port and mode decoder.
// Assumes inclusion by bare name from the design files.
`ifndef TWC_DEFS_SVH
`define TWC_DEFS_SVH
`define TWC_WORD_W 16
`define TWC_DATA_W 14
`define TWC_ADDR_W 2
`define TWC_ADDR_LSB 0
`define TWC_DATA_LSB 2
`define TWC_REG_RESET 14'h0000
`define TWC_REG_CHANNEL 2'h1
`define TWC_REG_TEST 2'h2
`define TWC_REG_CONFIG 2'h0
`define TWC_REG_CNT 3
// Idle levels of bus enable, chip enable, receive select and single carrier.
`define TWC_SYNC_IDLE 4'h8
`define TWC_EN_IDLE 1'b1
// Second intermediate frequency in kHz; applied as an offset on rx/tx switch.
`define TWC_IF2_KHZ 1024
`define TWC_CHAN_STEP_KHZ 1024
`endif

/* design/twc_pkg.sv */
// Types shared by the configuration port and mode decoder.
// Assumes twc_defs.svh is on the include path.
package twc_pkg;
    typedef enum logic [1:0] {
        TWC_MODE_STANDBY = 2'b00,
        TWC_MODE_RECEIVE = 2'b01,
        TWC_MODE_TRANSMIT = 2'b10
    } twc_mode_t;
    typedef logic [13:0] twc_data_t;
    typedef logic [1:0] twc_addr_t;
endpackage

/* design/twc_link_shift.sv */
// Serial-clock-domain shifter of the three-wire port.
// Assumes ser_clk is the host's bus clock and may stop between words.
`timescale 1ns/10ps
`default_nettype none
`include "twc_defs.svh"
module twc_link_shift #(
    parameter int WORD_W = `TWC_WORD_W
) (
    input wire logic ser_clk, // Bus clock from the host.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic bus_en, // Bus enable strobe, low during a word.
    input wire logic ser_data, // Serial data, most significant bit first.
    output logic [WORD_W-1:0] shift_q // Last bits shifted in.
);
    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] nxt_shift;

    always_comb begin
        nxt_shift = shift_ff;
        if (!bus_en) begin
            nxt_shift = {shift_ff[WORD_W-2:0], ser_data};
        end
    end

    // Holding while enabled keeps stray clocks from corrupting the word.
    always_ff @(posedge ser_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_ff <= '0;
        end else begin
            shift_ff <= nxt_shift;
        end
    end

    assign shift_q = shift_ff;
endmodule // twc_link_shift
`default_nettype wire

/* design/twc_config_port.sv */
// Three-wire write-only configuration port and operating mode decoder.
// Assumes the host drives bus enable, data and bus clock, and the two mode lines.
//
// Behaviour
// - Load the assembled word into the addressed register on enable rising.
// - While enable is high, ignore data and clock; shift register holds.
// - Each word is 16 bits: programming data plus two-bit register select.
// - With enable low, sample data on every bus clock rising edge.
// - Chip enable low forces standby whatever the receive select shows.
// - Chip enable high: receive select 1 gives receive, 0 gives transmit.
// - Host may rewrite the channel register at any time.
// - In single-carrier use, shift oscillator by second IF on rx/tx switch.
// - Word goes most significant bit first: 14 data bits then 2 address.
// - Registers are write-only; nothing reads them back over the bus.
`timescale 1ns/10ps
`default_nettype none
`include "twc_defs.svh"
module twc_config_port
    import twc_pkg::*;
#(
    parameter int WORD_W = `TWC_WORD_W,
    parameter int DATA_W = `TWC_DATA_W
) (
    input wire logic clk_sys, // System clock, 20 MHz.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic ser_clk, // Bus clock from the host.
    input wire logic bus_en, // Bus enable strobe.
    input wire logic ser_data, // Serial data.
    input wire logic chip_enable_in, // Chip enable line.
    input wire logic receive_select, // Receive select line.
    input wire logic single_carrier, // Single-carrier duplex use enabled.
    output twc_pkg::twc_mode_t mode, // Decoded operating mode.
    output logic powered_up, // High outside standby.
    output logic [DATA_W-1:0] cfg_reg0, // Configuration register 0.
    output logic [DATA_W-1:0] cfg_reg1, // Configuration register 1 (channel).
    output logic [DATA_W-1:0] cfg_reg2, // Configuration register 2 (test).
    output logic load_pulse, // One cycle when a register loads.
    output logic lo_offset_on // Oscillator shifted by the second IF.
);
    import twc_pkg::*;

    localparam int REG_CNT = `TWC_REG_CNT;
    localparam int PIN_CNT = 4;
    localparam int PIN_EN = 3;
    localparam int PIN_CE = 2;
    localparam int PIN_RX = 1;
    localparam int PIN_SC = 0;
    localparam logic [PIN_CNT-1:0] PIN_IDLE = `TWC_SYNC_IDLE;

    // The shifter lives on the host's bus clock, which may stop between words.
    logic [WORD_W-1:0] shift_q;
    twc_link_shift #(.WORD_W(WORD_W)) u_shift (
        .ser_clk(ser_clk),
        .arst_n(arst_n),
        .bus_en(bus_en),
        .ser_data(ser_data),
        .shift_q(shift_q)
    );

    logic [PIN_CNT-1:0] pins_raw;
    wire logic [PIN_CNT-1:0] pins_sync;

    assign pins_raw = {bus_en, chip_enable_in, receive_select, single_carrier};

    // Each stage resets to its pin's idle level; bus enable idles high, so a
    // zero reset would show a false rising edge and load a stale word.
    for (genvar p = 0; p < PIN_CNT; p++) begin : g_sync
        logic stage1_ff;
        logic stage2_ff;
        logic nxt_stage1;
        logic nxt_stage2;

        always_comb begin
            nxt_stage1 = pins_raw[p];
            nxt_stage2 = stage1_ff;
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                stage1_ff <= PIN_IDLE[p];
                stage2_ff <= PIN_IDLE[p];
            end else begin
                stage1_ff <= nxt_stage1;
                stage2_ff <= nxt_stage2;
            end
        end

        assign pins_sync[p] = stage2_ff;
    end

    // The word crosses from the bus clock domain with no handshake of its own:
    // the shifter holds it while enable is high, and it is sampled within three
    // system clocks of the rise. Enable must stay high that long between words.
    logic en_prev_ff;
    logic nxt_en_prev;
    logic en_rise;

    always_comb begin
        nxt_en_prev = pins_sync[PIN_EN];
        en_rise = pins_sync[PIN_EN] & ~en_prev_ff;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            en_prev_ff <= `TWC_EN_IDLE;
        end else begin
            en_prev_ff <= nxt_en_prev;
        end
    end

    twc_addr_t addr;
    logic [DATA_W-1:0] data;
    logic [REG_CNT-1:0] hit;

    always_comb begin
        addr = shift_q[`TWC_ADDR_LSB +: `TWC_ADDR_W];
        data = shift_q[`TWC_DATA_LSB +: DATA_W];
        hit = '0;
        if (en_rise) begin
            unique case (addr)
                `TWC_REG_CONFIG: hit[0] = 1'b1;
                `TWC_REG_CHANNEL: hit[1] = 1'b1;
                `TWC_REG_TEST: hit[2] = 1'b1;
                default: hit = '0;
            endcase
        end
    end

    // Only power-on reset clears a register; standby leaves every one alone.
    logic [DATA_W-1:0] cfg_q [REG_CNT];

    for (genvar r = 0; r < REG_CNT; r++) begin : g_reg
        logic [DATA_W-1:0] word_ff;
        logic [DATA_W-1:0] nxt_word;

        always_comb begin
            nxt_word = word_ff;
            if (hit[r]) begin
                nxt_word = data;
            end
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                word_ff <= `TWC_REG_RESET;
            end else begin
                word_ff <= nxt_word;
            end
        end

        assign cfg_q[r] = word_ff;
    end

    logic load_ff;
    logic nxt_load;

    always_comb begin
        nxt_load = |hit;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            load_ff <= 1'b0;
        end else begin
            load_ff <= nxt_load;
        end
    end

    twc_mode_t mode_ff;
    twc_mode_t nxt_mode;

    // Chip enable low wins over receive select, so standby needs one pin only.
    always_comb begin
        nxt_mode = TWC_MODE_STANDBY;
        unique case ({pins_sync[PIN_CE], pins_sync[PIN_RX]})
            2'b00: nxt_mode = TWC_MODE_STANDBY;
            2'b01: nxt_mode = TWC_MODE_STANDBY;
            2'b10: nxt_mode = TWC_MODE_TRANSMIT;
            2'b11: nxt_mode = TWC_MODE_RECEIVE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= TWC_MODE_STANDBY;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // The offset is applied only in transmit, so one channel word serves both
    // directions of a single-carrier slot pair.
    logic off_ff;
    logic nxt_off;

    always_comb begin
        nxt_off = pins_sync[PIN_SC] && (nxt_mode == TWC_MODE_TRANSMIT);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            off_ff <= 1'b0;
        end else begin
            off_ff <= nxt_off;
        end
    end

    // Outputs only drive the radio; nothing reads a register back.
    assign mode = mode_ff;
    assign powered_up = (mode_ff != TWC_MODE_STANDBY);
    assign cfg_reg0 = cfg_q[0];
    assign cfg_reg1 = cfg_q[1];
    assign cfg_reg2 = cfg_q[2];
    assign load_pulse = load_ff;
    assign lo_offset_on = off_ff;
endmodule // twc_config_port
`default_nettype wire

/* bench/twc_chk_properties.sv */
// Port assertions for twc_config_port.
// Assumes binding by port name.
`timescale 1ns/10ps
`default_nettype none
module twc_chk (
    input wire logic clk_sys, // Clock.
    input wire logic arst_n, // Reset.
    input wire logic chip_enable_in, // In.
    input wire logic receive_select, // In.
    input wire twc_pkg::twc_mode_t mode, // Out.
    input wire logic powered_up, // Out.
    input wire logic load_pulse, // Out.
    input wire logic lo_offset_on // Out.
);
    import twc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    stby_mode_a: assert property ((!chip_enable_in) [*4] |-> mode == TWC_MODE_STANDBY) else $error("stby");
    stby_fast_a: assert property ($fell(chip_enable_in) |-> ##[1:4] !powered_up) else $error("late");
    rx_mode_a: assert property ((chip_enable_in && receive_select) [*4] |-> mode == TWC_MODE_RECEIVE)
        else $error("rx");
    tx_mode_a: assert property ((chip_enable_in && !receive_select) [*4] |-> mode == TWC_MODE_TRANSMIT)
        else $error("tx");
    power_flag_a: assert property (powered_up == (mode != TWC_MODE_STANDBY) && powered_up == $past(chip_enable_in, 3))
        else $error("power");
    load_once_a: assert property (load_pulse |=> !load_pulse [*2]) else $error("load");
    offset_tx_a: assert property (lo_offset_on |-> mode == TWC_MODE_TRANSMIT || $past(mode) == TWC_MODE_TRANSMIT)
        else $error("offset");
    offset_off_a: assert property ((!chip_enable_in) [*6] |-> !lo_offset_on) else $error("off");
    cover property (mode == TWC_MODE_TRANSMIT ##1 mode == TWC_MODE_STANDBY);
    cover property (load_pulse);
    cover property (lo_offset_on);
endmodule // twc_chk
bind twc_config_port twc_chk u_chk (.*);
`default_nettype wire

/* bench/twc_host.sv */
// Behavioural host on the three-wire bus.
// Its 12 ns bus clock runs only inside send, with the strobe low unless hold_en is high.
`timescale 1ns/10ps
`default_nettype none
module twc_host (
    output logic ser_clk, // Clock.
    output logic bus_en, // Strobe.
    output logic ser_data // Data.
);
    initial {ser_clk, bus_en, ser_data} = 3'b010;
    // A high hold_en clocks with the strobe up, which the device must ignore.
    task automatic send(input logic [15:0] w, input int n, input logic hold_en);
        bus_en = hold_en;
        for (int i = n - 1; i >= 0; i--) begin
            ser_data = w[i];
            #6 ser_clk = 1'b1;
            #6 ser_clk = 1'b0;
        end
        #20 {bus_en, ser_data} = {1'b1, ~ser_data};
        #300;
    endtask
endmodule // twc_host
`default_nettype wire

/* bench/three_wire_config_and_mode_control_test.sv */
// Bench for twc_config_port.
// Assumes twc_host drives the bus.
`timescale 1ns/10ps
`default_nettype none
module three_wire_config_and_mode_control_test;
    import twc_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0, ser_clk, bus_en, ser_data, powered_up, load_pulse, lo_offset_on;
    logic chip_enable_in = 1'b0, receive_select = 1'b0, single_carrier = 1'b0;
    twc_mode_t mode;
    twc_data_t cfg_reg0, cfg_reg1, cfg_reg2;
    int miscompares = 0, total_checks = 0, loads = 0;
    twc_host host (.*);
    twc_config_port dut (.*);
    initial forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) loads += int'(load_pulse === 1'b1);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        miscompares += int'(got !== exp);
        if (got !== exp) $display("MISMATCH %0t %h %h", $time, got, exp);
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_serial();
        for (int a = 3; a >= 0; a--) begin
            host.send({14'h2a5c + 14'(a), 2'(a)}, 16, 1'b0);
            chk(16'(loads), 16'(3 - a));
        end
        chk(16'(cfg_reg2), 16'h2a5e);
        host.send(16'hffff, 4, 1'b1);
        chk(16'(dut.shift_q), {14'h2a5c, 2'h0});
        chk(16'(loads), 16'h3);
        $display("serial done");
    endtask
    task automatic t_modes();
        logic [2:0] v [5] = '{3'b110, 3'b101, 3'b100, 3'b011, 3'b001};
        foreach (v[i]) begin
            @(posedge clk_sys) {chip_enable_in, receive_select, single_carrier} <= v[i];
            #310;
            chk(16'({mode, powered_up, lo_offset_on}), 16'({v[i][2] ? (v[i][1] ? TWC_MODE_RECEIVE
                : TWC_MODE_TRANSMIT) : TWC_MODE_STANDBY, v[i][2], v[i] == 3'b101}));
            if (i == 0) begin
                #256000;
            end
        end
        host.send({14'h0123, 2'h1}, 16, 1'b0);
        chk(16'({mode, cfg_reg1}), 16'h0123);
        chk(16'(cfg_reg0), 16'h2a5c);
        $display("modes done");
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        #10 t_serial();
        t_modes();
        summarize();
    end
endmodule // three_wire_config_and_mode_control_test
`default_nettype wire
